// [core/tone_hit_pkg.sv]
package tone_hit_pkg;

	// ----------------------------------------------------------------
	// clock and timebase
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_US = 500;
	localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;

	// least times round up to whole ticks
	function automatic logic [11:0] us_to_ticks(input int us);
		return 12'((us + TICK_US - 1) / TICK_US);
	endfunction

	localparam int GAIN_HOLD_US = 3500;
	localparam int GAIN_FAST_US = 2500;
	localparam int RETURN_US = 4500;
	localparam int NET_CHECK_US = 200000;
	localparam int REBASE_US = 600000;
	localparam int WIN_SHORT_US = 125000;
	localparam int WIN_SECOND_US = 1000000;
	localparam logic [11:0] GAIN_HOLD_TICKS = us_to_ticks(GAIN_HOLD_US);
	localparam logic [11:0] GAIN_FAST_TICKS = us_to_ticks(GAIN_FAST_US);
	localparam logic [11:0] RETURN_TICKS = us_to_ticks(RETURN_US);
	localparam logic [11:0] NET_CHECK_TICKS = us_to_ticks(NET_CHECK_US);
	localparam logic [11:0] REBASE_TICKS = us_to_ticks(REBASE_US);
	localparam logic [11:0] WIN_SHORT_TICKS = us_to_ticks(WIN_SHORT_US);
	localparam logic [11:0] WIN_SECOND_TICKS = us_to_ticks(WIN_SECOND_US);

	// ----------------------------------------------------------------
	// measurement figures
	// ----------------------------------------------------------------
	localparam int LVL_W = 8;
	localparam logic [11:0] FULL_CYCLE_TENTHS = 12'hE10;
	localparam logic [7:0] JIT_MAX_TENTHS = 8'hFA;
	localparam logic signed [7:0] LVL_MIN_DBM = -8'sd40;
	localparam logic signed [7:0] LVL_MAX_DBM = 8'sd10;
	localparam logic [7:0] PH_THR_MIN = 8'h05;
	localparam logic [7:0] PH_THR_MAX = 8'h2D;
	localparam logic [7:0] PH_BIG_DEG = 8'h0F;
	localparam logic [1:0] PH_TRIG_RUN = 2'h3;
	localparam logic [1:0] PH_TRIG_BIG = 2'h2;
	localparam logic [2:0] PH_REARM_CYCLES = 3'h4;
	localparam logic [7:0] GAIN_THR_MIN = 8'h02;
	localparam logic [7:0] GAIN_THR_MAX = 8'h0A;
	localparam logic [8:0] GAIN_BIG_DB = 9'h004;
	localparam logic [8:0] GAIN_NET_DB = 9'h004;
	localparam logic [8:0] DROP_DB = 9'h00C;
	localparam logic [7:0] IMP_STEP_DB = 8'h04;
	localparam logic [7:0] IMP_LO_DEF = 8'h44;
	localparam int BANDLIMIT_HP_HZ = 700;
	localparam int BANDLIMIT_LP_HZ = 1300;
	localparam int STD_BAND_LO_HZ = 20;
	localparam int LF_BAND_LO_HZ = 4;
	localparam int BAND_HI_HZ = 300;

	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_OUT = 2'b01,
		G_LONG = 2'b10
	} gain_state_type;

endpackage

// [core/tone_hit_counter.sv]
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RL1: each second keep longest/shortest period; jitter = spread / mean period * 360.
// RL2: reported jitter is limited to 0 through 25 degrees.
// RL3: level outside -40..+10 dBm flags tone loss instead of results.
// RL4: jitter path is band-limited 700 Hz to 1300 Hz upstream; the code enables it only with a 600 ohm termination active.
// RL5: weighting band steps between standard 20-300 Hz and low 4-300 Hz.
// RL6: band selection only works with a 600 ohm termination active.
// RL7: phase hit on three intervals over threshold, or two 15 degrees beyond.
// RL8: phase hit threshold is held between 5 and 45 degrees.
// RL9: one phase hit per 125 ms window started by the first crossing.
// RL10: gain hit after 3.5 ms (2.5 ms if 4 dB beyond), limited per 125 ms.
// RL11: no return by 4.5 ms and 4 dB net at 200 ms counts a hit.
// RL12: still outside at 600 ms drops the hit and takes the new level.
// RL13: dropout on 12 dB fall beyond 4.5 ms, at most one per second.
// RL14: three impulse thresholds 4 dB apart, lowest default 68, 125 ms limit.
// RL15: hit and dropout path uses C-message weighting upstream; the code enables it only with a 600 ohm termination active.
// RL16: fast count removes all 125 ms and one second limits.
// RL17: leaving threshold editing zeros transient counts and restarts the timer.
// RL18: clear zeros impulse counts and restarts the timer.
// RL19: counting stops when the timed duration ends; 0h 0m runs forever.
// RL20: elapsed timer in h:m:s advances each second while counting.
module tone_hit_counter #(
	parameter int unsigned TICK_CYCLES = tone_hit_pkg::TICK_CYCLES_DEF,
	parameter int CNT_W = 16
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_term_600,
	input wire logic i_band_step,
	input wire logic i_cycle_done,
	input wire logic [15:0] i_cycle_period,
	input wire logic [7:0] i_phase_dev,
	input wire logic signed [tone_hit_pkg::LVL_W-1:0] i_level_dbm,
	input wire logic i_impulse_hit,
	input wire logic [7:0] i_impulse_dbrn,
	input wire logic [7:0] i_phase_thr,
	input wire logic [7:0] i_gain_thr,
	input wire logic i_imp_thr_wr,
	input wire logic [7:0] i_imp_thr_value,
	input wire logic i_fast_count,
	input wire logic i_edit_exit,
	input wire logic i_clear,
	input wire logic [7:0] i_test_hours,
	input wire logic [5:0] i_test_minutes,
	output logic [7:0] o_jitter_tenths,
	output logic o_tone_loss,
	output logic o_jitter_bandlimit_en,
	output logic o_cmsg_weight_en,
	output logic o_low_frequency_weighting_band,
	output logic [CNT_W-1:0] o_phase_hits,
	output logic [CNT_W-1:0] o_gain_hits,
	output logic [CNT_W-1:0] o_dropouts,
	output logic [CNT_W-1:0] o_lowest_impulse_count,
	output logic [CNT_W-1:0] o_mid_impulse_count,
	output logic [CNT_W-1:0] o_upper_impulse_count,
	output logic [7:0] o_lowest_impulse_threshold,
	output logic [7:0] o_elapsed_hours,
	output logic [5:0] o_elapsed_minutes,
	output logic [5:0] o_elapsed_seconds,
	output logic o_test_running
);
	import tone_hit_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] div;
		logic [11:0] sec_cnt;
		logic [15:0] per_max;
		logic [15:0] per_min;
		logic [25:0] per_sum;
		logic [10:0] per_n;
		logic [7:0] jitter;
		logic tone_loss;
		logic term_en;
		logic lf_band;
		logic [1:0] ph_run;
		logic [1:0] ph_big;
		logic [2:0] ph_in;
		logic ph_armed;
		logic ph_used;
		logic [11:0] ph_win;
		gain_state_type gst;
		logic g_big;
		logic [11:0] g_t;
		logic signed [7:0] avg;
		logic [11:0] g_win;
		logic [3:0] d_t;
		logic d_done;
		logic [11:0] d_win;
		logic [7:0] imp_lo;
		logic [2:0][11:0] i_win;
		logic [CNT_W-1:0] ph_cnt;
		logic [CNT_W-1:0] g_cnt;
		logic [CNT_W-1:0] d_cnt;
		logic [2:0][CNT_W-1:0] i_cnt;
		logic [7:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
		logic running;
	} st_type;

	st_type st_q;
	st_type st_d;

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		return (&v) ? v : v + CNT_W'(1);
	endfunction

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
			input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [11:0] win_dec(input logic [11:0] w, input logic tk);
		return (tk && w != 12'h000) ? w - 12'h001 : w;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic tick;
		logic sec;
		logic cnt_en;
		logic [39:0] num;
		logic [39:0] jq;
		logic [7:0] pthr;
		logic [7:0] gthr;
		logic ph_out;
		logic ph_big_now;
		logic [1:0] run_n;
		logic [1:0] big_n;
		logic signed [8:0] gdev;
		logic [8:0] gadev;
		logic g_out;
		logic g_hit;
		logic [7:0] ithr;
		tick = 1'b0;
		sec = 1'b0;
		cnt_en = 1'b0;
		num = 40'h0;
		jq = 40'h0;
		pthr = 8'h00;
		gthr = 8'h00;
		ph_out = 1'b0;
		ph_big_now = 1'b0;
		run_n = 2'h0;
		big_n = 2'h0;
		gdev = 9'sh000;
		gadev = 9'h000;
		g_out = 1'b0;
		g_hit = 1'b0;
		ithr = 8'h00;
		st_d = st_q;

		tick = (st_q.div == 16'(TICK_CYCLES - 1));
		st_d.div = tick ? 16'h0000 : st_q.div + 16'h0001;
		sec = tick && (st_q.sec_cnt == WIN_SECOND_TICKS - 12'h001);
		if (tick) begin
			st_d.sec_cnt = sec ? 12'h000 : st_q.sec_cnt + 12'h001;
		end
		st_d.tone_loss = (i_level_dbm < LVL_MIN_DBM) || (i_level_dbm > LVL_MAX_DBM); // RL3
		cnt_en = st_q.running && !st_q.tone_loss;
		st_d.term_en = i_term_600; // RL4 RL15

		// ------------------------------------------------------------
		// weighting band
		// ------------------------------------------------------------
		if (!i_term_600) begin
			st_d.lf_band = 1'b0; // RL6
		end else if (i_band_step) begin
			st_d.lf_band = !st_q.lf_band; // RL5
		end

		// ------------------------------------------------------------
		// phase jitter
		// ------------------------------------------------------------
		if (i_cycle_done) begin
			if (i_cycle_period > st_q.per_max) begin
				st_d.per_max = i_cycle_period; // RL1
			end
			if (i_cycle_period < st_q.per_min) begin
				st_d.per_min = i_cycle_period; // RL1
			end
			st_d.per_sum = st_q.per_sum + 26'(i_cycle_period);
			st_d.per_n = (&st_q.per_n) ? st_q.per_n : st_q.per_n + 11'h001;
		end
		if (sec) begin
			// a cycle ending on the boundary cycle is dropped; one sample in a thousand
			if (st_q.per_n != 11'h000 && st_q.per_sum != 26'h0) begin
				num = 40'(st_q.per_max - st_q.per_min) * 40'(st_q.per_n)
					* 40'(FULL_CYCLE_TENTHS);
				jq = num / 40'(st_q.per_sum); // RL1
			end
			st_d.jitter = (jq > 40'(JIT_MAX_TENTHS)) ? JIT_MAX_TENTHS : jq[7:0]; // RL2
			st_d.per_max = 16'h0000;
			st_d.per_min = 16'hFFFF;
			st_d.per_sum = 26'h0;
			st_d.per_n = 11'h000;
		end
		if (st_q.tone_loss) begin
			st_d.jitter = 8'h00; // RL3
		end

		// ------------------------------------------------------------
		// phase hits
		// ------------------------------------------------------------
		pthr = clamp(i_phase_thr, PH_THR_MIN, PH_THR_MAX); // RL8
		st_d.ph_win = win_dec(st_q.ph_win, tick);
		if (tick && st_q.ph_win == 12'h001) begin
			st_d.ph_used = 1'b0;
		end
		if (i_cycle_done && cnt_en) begin
			ph_out = i_phase_dev > pthr;
			ph_big_now = {1'b0, i_phase_dev} >= ({1'b0, pthr} + {1'b0, PH_BIG_DEG});
			run_n = (st_q.ph_run == 2'h3) ? 2'h3 : st_q.ph_run + 2'h1;
			big_n = (st_q.ph_big == 2'h3) ? 2'h3 : st_q.ph_big + 2'h1;
			if (ph_out) begin
				st_d.ph_in = 3'h0;
				st_d.ph_run = run_n;
				st_d.ph_big = ph_big_now ? big_n : 2'h0;
				if (st_q.ph_win == 12'h000 && !st_q.ph_used) begin
					st_d.ph_win = WIN_SHORT_TICKS; // RL9
				end
				if (st_q.ph_armed && (run_n >= PH_TRIG_RUN
						|| (ph_big_now && big_n >= PH_TRIG_BIG))) begin // RL7
					st_d.ph_armed = 1'b0;
					if (!st_q.ph_used || i_fast_count) begin // RL9 RL16
						st_d.ph_cnt = sat_inc(st_q.ph_cnt);
						st_d.ph_used = 1'b1;
					end
				end
			end else begin
				st_d.ph_run = 2'h0;
				st_d.ph_big = 2'h0;
				st_d.ph_in = (st_q.ph_in == 3'h7) ? 3'h7 : st_q.ph_in + 3'h1;
				if (st_q.ph_in + 3'h1 >= PH_REARM_CYCLES) begin
					st_d.ph_armed = 1'b1; // RL7
				end
			end
		end

		// ------------------------------------------------------------
		// gain hits
		// ------------------------------------------------------------
		gthr = clamp(i_gain_thr, GAIN_THR_MIN, GAIN_THR_MAX);
		gdev = 9'(i_level_dbm) - 9'(st_q.avg);
		gadev = gdev[8] ? 9'(-gdev) : 9'(gdev);
		g_out = gadev >= {1'b0, gthr};
		st_d.g_win = win_dec(st_q.g_win, tick);
		if (!cnt_en) begin
			st_d.gst = G_IDLE;
		end else if (tick) begin
			case (st_q.gst)
				G_IDLE: begin
					if (g_out) begin
						st_d.gst = G_OUT;
						st_d.g_t = 12'h001;
						st_d.g_big = gadev >= {1'b0, gthr} + GAIN_BIG_DB;
					end else if (i_level_dbm > st_q.avg) begin
						st_d.avg = st_q.avg + 8'sd1;
					end else if (i_level_dbm < st_q.avg) begin
						st_d.avg = st_q.avg - 8'sd1;
					end
				end
				G_OUT: begin
					st_d.g_t = st_q.g_t + 12'h001;
					if (gadev >= {1'b0, gthr} + GAIN_BIG_DB) begin
						st_d.g_big = 1'b1;
					end
					if (!g_out) begin
						st_d.gst = G_IDLE;
						g_hit = st_q.g_t >= (st_q.g_big ? GAIN_FAST_TICKS
							: GAIN_HOLD_TICKS); // RL10
					end else if (st_q.g_t >= RETURN_TICKS) begin
						st_d.gst = G_LONG; // RL11
					end
				end
				G_LONG: begin
					st_d.g_t = st_q.g_t + 12'h001;
					if (!g_out) begin
						st_d.gst = G_IDLE;
					end else if (st_q.g_t == REBASE_TICKS - 12'h001) begin
						st_d.avg = i_level_dbm; // RL12
						st_d.gst = G_IDLE;
					end else if (st_q.g_t == NET_CHECK_TICKS - 12'h001) begin
						g_hit = gadev >= GAIN_NET_DB; // RL11
					end
				end
				default: begin
					st_d.gst = G_IDLE;
				end
			endcase
		end
		if (g_hit && (st_q.g_win == 12'h000 || i_fast_count)) begin // RL10 RL16
			st_d.g_cnt = sat_inc(st_q.g_cnt);
			st_d.g_win = WIN_SHORT_TICKS;
		end

		// ------------------------------------------------------------
		// dropouts
		// ------------------------------------------------------------
		st_d.d_win = win_dec(st_q.d_win, tick);
		if (tick && cnt_en) begin
			if (gdev <= -$signed(DROP_DB)) begin
				st_d.d_t = (st_q.d_t == 4'hF) ? 4'hF : st_q.d_t + 4'h1;
				if (st_q.d_t >= RETURN_TICKS[3:0] && !st_q.d_done) begin // RL13
					st_d.d_done = 1'b1;
					if (st_q.d_win == 12'h000 || i_fast_count) begin // RL16
						st_d.d_cnt = sat_inc(st_q.d_cnt);
						st_d.d_win = WIN_SECOND_TICKS; // RL13
					end
				end
			end else begin
				st_d.d_t = 4'h0;
				st_d.d_done = 1'b0;
			end
		end

		// ------------------------------------------------------------
		// impulse noise
		// ------------------------------------------------------------
		if (i_imp_thr_wr) begin
			st_d.imp_lo = i_imp_thr_value; // RL14
		end
		for (int k = 0; k < 3; k++) begin
			ithr = st_q.imp_lo + 8'(k * 4);
			st_d.i_win[k] = win_dec(st_q.i_win[k], tick);
			if (i_impulse_hit && cnt_en && i_impulse_dbrn >= ithr
					&& (st_q.i_win[k] == 12'h000 || i_fast_count)) begin // RL14 RL16
				st_d.i_cnt[k] = sat_inc(st_q.i_cnt[k]);
				st_d.i_win[k] = WIN_SHORT_TICKS;
			end
		end

		// ------------------------------------------------------------
		// test timer
		// ------------------------------------------------------------
		st_d.running = (i_test_hours == 8'h00 && i_test_minutes == 6'h00)
			|| ({st_q.hh, st_q.mm} < {i_test_hours, i_test_minutes}); // RL19
		if (sec && st_q.running) begin // RL20
			st_d.ss = (st_q.ss == 6'h3B) ? 6'h00 : st_q.ss + 6'h01;
			if (st_q.ss == 6'h3B) begin
				st_d.mm = (st_q.mm == 6'h3B) ? 6'h00 : st_q.mm + 6'h01;
				if (st_q.mm == 6'h3B) begin
					st_d.hh = st_q.hh + 8'h01;
				end
			end
		end

		// clears come last so they win over a count in the same cycle
		if (i_edit_exit) begin // RL17
			st_d.ph_cnt = '0;
			st_d.g_cnt = '0;
			st_d.d_cnt = '0;
		end
		if (i_clear) begin // RL18
			st_d.i_cnt = '0;
		end
		if (i_edit_exit || i_clear) begin // RL17 RL18
			st_d.hh = 8'h00;
			st_d.mm = 6'h00;
			st_d.ss = 6'h00;
		end

		if (i_sys_rst) begin
			st_d = '0;
			st_d.per_min = 16'hFFFF;
			st_d.imp_lo = IMP_LO_DEF;
			st_d.ph_armed = 1'b1;
			st_d.gst = G_IDLE;
		end
	end

	always_ff @(posedge i_clk) begin
		st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_jitter_tenths = st_q.jitter;
	assign o_tone_loss = st_q.tone_loss;
	assign o_jitter_bandlimit_en = st_q.term_en;
	assign o_cmsg_weight_en = st_q.term_en;
	assign o_low_frequency_weighting_band = st_q.lf_band;
	assign o_phase_hits = st_q.ph_cnt;
	assign o_gain_hits = st_q.g_cnt;
	assign o_dropouts = st_q.d_cnt;
	assign o_lowest_impulse_count = st_q.i_cnt[0];
	assign o_mid_impulse_count = st_q.i_cnt[1];
	assign o_upper_impulse_count = st_q.i_cnt[2];
	assign o_lowest_impulse_threshold = st_q.imp_lo;
	assign o_elapsed_hours = st_q.hh;
	assign o_elapsed_minutes = st_q.mm;
	assign o_elapsed_seconds = st_q.ss;
	assign o_test_running = st_q.running;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_jit_range;
		o_jitter_tenths <= JIT_MAX_TENTHS;
	endproperty
	a_jit_range: assert property (p_jit_range) else $error("jitter above range"); // RL2

	property p_loss_blanks;
		st_q.tone_loss |=> o_jitter_tenths == 8'h00
			&& o_tone_loss == $past(i_level_dbm < LVL_MIN_DBM || i_level_dbm > LVL_MAX_DBM);
	endproperty
	a_loss_blanks: assert property (p_loss_blanks) else $error("jitter shown at loss"); // RL3

	property p_ph_once;
		st_q.ph_used && !i_fast_count && !i_edit_exit |=> $stable(o_phase_hits);
	endproperty
	a_ph_once: assert property (p_ph_once) else $error("second phase hit in window"); // RL9

	property p_gain_once;
		st_q.g_win != 12'h000 && !i_fast_count && !i_edit_exit |=> $stable(o_gain_hits);
	endproperty
	a_gain_once: assert property (p_gain_once) else $error("gain hit too soon"); // RL10

	property p_drop_once;
		st_q.d_win != 12'h000 && !i_fast_count && !i_edit_exit |=> $stable(o_dropouts);
	endproperty
	a_drop_once: assert property (p_drop_once) else $error("dropout too soon"); // RL13

	property p_edit_zero;
		i_edit_exit |=> o_phase_hits == '0 && o_gain_hits == '0 && o_dropouts == '0
			&& o_elapsed_seconds == 6'h00 && o_elapsed_minutes == 6'h00;
	endproperty
	a_edit_zero: assert property (p_edit_zero) else $error("edit exit left counts"); // RL17

	property p_clear_zero;
		i_clear |=> o_lowest_impulse_count == '0 && o_upper_impulse_count == '0
			&& o_elapsed_hours == 8'h00;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear left counts"); // RL18

	property p_halted;
		!st_q.running && !i_clear && !i_edit_exit |=> $stable(o_elapsed_seconds)
			&& $stable(o_lowest_impulse_count);
	endproperty
	a_halted: assert property (p_halted) else $error("counting after test end"); // RL19

	property p_band_gate;
		!i_term_600 |=> !o_low_frequency_weighting_band;
	endproperty
	a_band_gate: assert property (p_band_gate) else $error("band without 600 ohm"); // RL6

endmodule

`default_nettype wire

// [sim/tone_line_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// received tone: cycles alternate between two lengths
// ----------------------------------------------------------------
module tone_line_model (
	input wire logic i_clk,
	input wire logic [15:0] i_period_a,
	input wire logic [15:0] i_period_b,
	output logic o_cycle_done,
	output logic [15:0] o_cycle_period
);
	logic [15:0] count_q;
	logic alt_q;
	initial begin
		count_q = 16'h0001;
		alt_q = 1'b0;
		o_cycle_done = 1'b0;
		o_cycle_period = 16'h0000;
	end
	always @(posedge i_clk) begin
		o_cycle_done <= 1'b0;
		// period only valid with the strobe, so scramble it otherwise
		o_cycle_period <= ~o_cycle_period;
		if (count_q >= (alt_q ? i_period_b : i_period_a)) begin
			o_cycle_done <= 1'b1;
			o_cycle_period <= alt_q ? i_period_b : i_period_a;
			alt_q <= !alt_q;
			count_q <= 16'h0001;
		end else begin
			count_q <= count_q + 16'h0001;
		end
	end
endmodule

`default_nettype wire

// [sim/tone_impairment_hit_counter_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module tone_impairment_hit_counter_bench;
	import tone_hit_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	// short tick keeps a one second jitter interval at 10000 clocks
	localparam int TICK = 5;
	// which strobe the pulse task raises
	localparam int P_STEP = 0, P_EDIT = 1, P_CLR = 2, P_THR = 3;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic term = 1'b0, step = 1'b0, imp = 1'b0, thr_wr = 1'b0;
	logic fast = 1'b0, edit_exit = 1'b0, clr = 1'b0, cyc_done;
	logic [15:0] per_a = 16'h0014, per_b = 16'h0014, cyc_per;
	logic [7:0] dev = 8'h00, dbrn = 8'h00, ph_thr = 8'h0A, g_thr = 8'h04, thr_val = 8'h44;
	logic [7:0] dur_h = 8'h00;
	logic [5:0] dur_m = 6'h00;
	logic signed [7:0] level = 8'h00;
	logic [7:0] jit, lo_thr, hrs;
	logic loss, bl_en, cm_en, band, running;
	logic [15:0] ph, gh, dr, c_lo, c_mid, c_up;
	logic [5:0] mins, secs;
	int miscompares = 0, samples_checked = 0, cycles = 0;

	always #12.5 clk = ~clk;

	tone_line_model i_line (.i_clk(clk), .i_period_a(per_a), .i_period_b(per_b),
		.o_cycle_done(cyc_done), .o_cycle_period(cyc_per));

	tone_hit_counter #(.TICK_CYCLES(TICK), .CNT_W(16)) i_dut (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_term_600(term), .i_band_step(step),
		.i_cycle_done(cyc_done), .i_cycle_period(cyc_per), .i_phase_dev(dev),
		.i_level_dbm(level), .i_impulse_hit(imp), .i_impulse_dbrn(dbrn),
		.i_phase_thr(ph_thr), .i_gain_thr(g_thr), .i_imp_thr_wr(thr_wr),
		.i_imp_thr_value(thr_val), .i_fast_count(fast), .i_edit_exit(edit_exit),
		.i_clear(clr), .i_test_hours(dur_h), .i_test_minutes(dur_m),
		.o_jitter_tenths(jit), .o_tone_loss(loss), .o_jitter_bandlimit_en(bl_en),
		.o_cmsg_weight_en(cm_en), .o_low_frequency_weighting_band(band),
		.o_phase_hits(ph), .o_gain_hits(gh), .o_dropouts(dr),
		.o_lowest_impulse_count(c_lo), .o_mid_impulse_count(c_mid),
		.o_upper_impulse_count(c_up), .o_lowest_impulse_threshold(lo_thr),
		.o_elapsed_hours(hrs), .o_elapsed_minutes(mins), .o_elapsed_seconds(secs),
		.o_test_running(running));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("counts: %0d checked, %0d mismatched", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic clocks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			P_STEP: step <= 1'b1;
			P_EDIT: edit_exit <= 1'b1;
			P_CLR: clr <= 1'b1;
			default: thr_wr <= 1'b1;
		endcase
		@(posedge clk);
		step <= 1'b0;
		edit_exit <= 1'b0;
		clr <= 1'b0;
		thr_wr <= 1'b0;
		clocks(2);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) begin
			@(posedge clk);
			while (cyc_done !== 1'b1) @(posedge clk);
		end
	endtask

	task automatic burst(input logic [7:0] thr, input logic [7:0] d, input int n,
		input logic [15:0] exp);
		ph_thr <= thr;
		wait_cyc(1);
		dev <= d;
		wait_cyc(n);
		dev <= 8'h00;
		wait_cyc(5);
		check(ph, exp, "phase hits");
	endtask

	task automatic impulse(input logic [7:0] v);
		@(posedge clk);
		imp <= 1'b1;
		dbrn <= v;
		@(posedge clk);
		imp <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		clocks(8);
		sys_rst <= 1'b0;
		clocks(3);
		check(lo_thr, 16'h0044, "lowest threshold default");
		check(ph | gh | dr | c_lo, 16'h0000, "counts after reset");
		check(running, 1'b1, "running with 0h 0m");
		dur_m <= 6'h01;
		clocks(3);
		check(running, 1'b1, "running inside duration");
		dur_m <= 6'h00;
		$display("test reset done");
	endtask

	task automatic test_band();
		pulse(P_STEP);
		check(band, 1'b0, "band step without termination");
		check({bl_en, cm_en}, 2'h0, "filters off without termination");
		term <= 1'b1;
		clocks(2);
		check({bl_en, cm_en}, 2'h3, "filters follow termination");
		pulse(P_STEP);
		check(band, 1'b1, "low frequency band");
		pulse(P_STEP);
		check(band, 1'b0, "standard band");
		$display("test band done");
	endtask

	task automatic test_tone_loss();
		logic [7:0] lv[4] = '{8'hD7, 8'hD8, 8'h0A, 8'h0B};
		logic ex[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		for (int k = 0; k < 4; k++) begin
			level <= lv[k];
			clocks(3);
			check(loss, ex[k], "tone loss window");
		end
		level <= 8'h00;
		clocks(3);
		$display("test tone loss done");
	endtask

	task automatic test_phase();
		burst(8'h0A, 8'h14, 3, 16'h0001);
		burst(8'h0A, 8'h14, 3, 16'h0001);
		fast <= 1'b1;
		burst(8'h0A, 8'h14, 3, 16'h0002);
		burst(8'h0A, 8'h19, 2, 16'h0003);
		burst(8'h0A, 8'h18, 2, 16'h0003);
		burst(8'h00, 8'h06, 3, 16'h0004);
		burst(8'h64, 8'h2C, 3, 16'h0004);
		burst(8'h64, 8'h2E, 3, 16'h0005);
		fast <= 1'b0;
		$display("test phase done");
	endtask

	task automatic test_gain_drop();
		level <= 8'hFA;
		clocks(8 * TICK);
		level <= 8'h00;
		clocks(20 * TICK);
		check(gh, 16'h0001, "gain hit");
		level <= 8'hF3;
		clocks(12 * TICK);
		level <= 8'h00;
		clocks(30 * TICK);
		check(dr, 16'h0001, "dropout");
		fast <= 1'b1;
		level <= 8'hF8;
		clocks(1300 * TICK);
		check(gh, 16'h0002, "long excursion net change");
		level <= 8'hF2;
		clocks(8 * TICK);
		level <= 8'hF8;
		clocks(5 * TICK);
		check(gh, 16'h0003, "hit against adopted level");
		check(dr, 16'h0001, "no dropout against adopted level");
		level <= 8'h00;
		fast <= 1'b0;
		pulse(P_EDIT);
		check(ph | gh | dr, 16'h0000, "edit exit zeroes");
		check(secs, 6'h00, "edit exit timer");
		$display("test gain and dropout done");
	endtask

	task automatic test_impulse();
		level <= 8'h0B;
		impulse(8'h50);
		level <= 8'h00;
		clocks(3);
		check(c_lo, 16'h0000, "no count in tone loss");
		impulse(8'h44);
		impulse(8'h44);
		clocks(2);
		check(c_lo, 16'h0001, "impulse rate limit");
		fast <= 1'b1;
		impulse(8'h43);
		impulse(8'h44);
		impulse(8'h48);
		impulse(8'h4C);
		clocks(2);
		check(c_lo, 16'h0004, "lowest count");
		check(c_mid, 16'h0002, "mid count");
		check(c_up, 16'h0001, "upper count");
		thr_val <= 8'h46;
		pulse(P_THR);
		check(lo_thr, 16'h0046, "threshold load");
		impulse(8'h49);
		clocks(2);
		check(c_lo, 16'h0005, "moved lowest threshold");
		check(c_mid, 16'h0002, "moved mid threshold");
		fast <= 1'b0;
		pulse(P_CLR);
		check(c_lo | c_mid | c_up, 16'h0000, "clear zeroes");
		check(secs, 6'h00, "clear timer");
		$display("test impulse done");
	endtask

	task automatic test_jitter();
		logic [5:0] s1;
		per_a <= 16'h00F5;
		per_b <= 16'h00FF;
		clocks(2);
		// line up with a second boundary so the next interval is all new periods
		s1 = secs;
		while (secs == s1) @(posedge clk);
		s1 = secs;
		clocks(10005);
		check(secs, 6'(s1 + 6'h01), "elapsed seconds");
		check({2'b00, hrs, mins}, 16'h0000, "elapsed hours and minutes");
		check(jit >= 8'h8F && jit <= 8'h91, 1'b1, "jitter value");
		pulse(P_CLR);
		check(secs, 6'h00, "clear restarts timer");
		per_a <= 16'h00E1;
		per_b <= 16'h0113;
		clocks(20500);
		check(jit, 16'h00FA, "jitter ceiling");
		pulse(P_EDIT);
		check(secs, 6'h00, "edit exit restarts timer");
		$display("test jitter done");
	endtask

	initial begin
		test_reset();
		test_band();
		test_tone_loss();
		test_phase();
		test_gain_drop();
		test_impulse();
		test_jitter();
		conclude();
	end
endmodule

`default_nettype wire
